// *** cpsrg_regs.sv ***
// Flags word, program counter and system stack pointer of the core.
// Assumes the decoder holds off new ops while o_busy is high and that
// local memory answers each stack request with a one-cycle i_mem_ack.
`timescale 1ns/100ps
module cpsrg_regs (
  // Clock and reset.
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  // Decoder side.
  input  wire cpsrg_pkg::cpsrg_op_type i_op,
  input  wire logic [31:0]           i_operand,
  input  wire logic                  i_field_sel,
  input  wire logic                  i_mid_instr,
  input  wire logic                  i_fetch,
  input  wire logic                  i_instr_done,
  // ALU result flags {n, c, z, v}.
  input  wire logic                  i_alu_we,
  input  wire logic [3:0]            i_alu_flags,
  // Local memory side.
  input  wire logic                  i_bus_fault,
  input  wire logic                  i_mem_ack,
  input  wire logic [31:0]           i_mem_rdata,
  output logic                       o_mem_req,
  output logic                       o_mem_we,
  output logic [31:0]                o_mem_addr,
  output logic [31:0]                o_mem_wdata,
  // State outputs.
  output logic                       o_busy,
  output logic [31:0]                o_flags,
  output logic [31:0]                o_pc,
  output logic [31:0]                o_sp,
  output logic                       o_int_gate,
  output logic                       o_step_irq,
  output logic [5:0]                 o_field0_len,
  output logic [5:0]                 o_field1_len,
  // Register file write-back.
  output logic                       o_gpr_we,
  output logic [31:0]                o_gpr_wdata
);
  import cpsrg_pkg::*;

  // ==========================================================
  // State registers
  logic [31:0]     flags_q, flags_d;
  logic [31:4]     pc_q, pc_d;
  logic [31:0]     sp_q, sp_d;
  logic [31:4]     tgt_q, tgt_d;
  logic            tgt_load_q, tgt_load_d;
  logic            two_q, two_d;
  cpsrg_state_type state_q, state_d;
  logic            req_q, req_d;
  logic            we_q, we_d;
  logic [31:0]     wdata_q, wdata_d;
  logic            gwe_q, gwe_d;
  logic [31:0]     gdata_q, gdata_d;
  logic            step_q;
  logic            busy_q;
  logic [5:0]      len_q [2];

  // ==========================================================
  // Decoded helper values
  wire         idle     = (state_q == ST_IDLE);
  wire         take     = idle && (i_op != OP_NONE);
  wire [31:0]  sp_align = {sp_q[31:SP_LOW], 5'h00};
  wire [31:0]  sp_push  = sp_align - STACK_STEP;
  wire [31:0]  sp_down  = sp_q - STACK_STEP;
  wire [31:0]  sp_up    = sp_q + STACK_STEP;
  wire [31:0]  pc_full  = {pc_q, 4'h0};
  wire [27:0]  disp8    = {{20{i_operand[7]}}, i_operand[7:0]};
  wire [27:0]  disp16   = {{12{i_operand[15]}}, i_operand[15:0]};
  wire [27:0]  rel8_pc  = pc_q + disp8;
  wire [27:0]  rel16_pc = pc_q + disp16;
  wire [4:0]   fsh      = i_field_sel ? 5'd6 : 5'd0;
  wire [5:0]   fold     = flags_q[fsh +: FIELD_SPAN];

  // Next-state logic for the three registers and the stack sequencer.
  always_comb begin
    flags_d    = flags_q;
    pc_d       = pc_q;
    sp_d       = sp_q;
    tgt_d      = tgt_q;
    tgt_load_d = tgt_load_q;
    two_d      = two_q;
    state_d    = state_q;
    req_d      = req_q;
    we_d       = we_q;
    wdata_d    = wdata_q;
    gwe_d      = 1'b0;
    gdata_d    = gdata_q;
    if (i_fetch) begin
      pc_d = pc_q + 28'h000_0001;
    end
    if (i_alu_we) begin
      flags_d[31:ARITH_LSB] = i_alu_flags;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          unique case (i_op)
            OP_LOAD_FLAGS: flags_d = i_operand & USED_MASK;
            OP_COPY_FLAGS: begin
              gwe_d   = 1'b1;
              gdata_d = flags_q;
            end
            OP_CARRY_SET:   flags_d[C_BIT] = 1'b1;
            OP_CARRY_CLEAR: flags_d[C_BIT] = 1'b0;
            OP_INTS_ON:     flags_d[IE_BIT] = 1'b1;
            OP_INTS_OFF:    flags_d[IE_BIT] = 1'b0;
            OP_FIELD_WRITE: flags_d[fsh +: FIELD_SPAN] = i_operand[5:0];
            OP_FIELD_SWAP: begin
              flags_d[fsh +: FIELD_SPAN] = i_operand[5:0];
              gwe_d   = 1'b1;
              gdata_d = {i_operand[31:6], fold};
            end
            OP_COUNTER_READ: begin
              gwe_d   = 1'b1;
              gdata_d = pc_full;
            end
            OP_COUNTER_SWAP: begin
              gwe_d   = 1'b1;
              gdata_d = pc_full;
              pc_d    = i_operand[31:PC_LOW];
            end
            OP_ABS_BRANCH:   pc_d = i_operand[31:PC_LOW];
            OP_IND_BRANCH:   pc_d = i_operand[31:PC_LOW];
            OP_REL8_BRANCH:  pc_d = rel8_pc;
            OP_REL16_BRANCH: pc_d = rel16_pc;
            OP_SP_WRITE:     sp_d = i_operand;
            OP_SP_READ: begin
              gwe_d   = 1'b1;
              gdata_d = sp_q;
            end
            OP_FLAGS_PUSH: begin
              sp_d       = sp_down;
              wdata_d    = flags_q;
              we_d       = 1'b1;
              req_d      = 1'b1;
              tgt_load_d = 1'b0;
              state_d    = ST_PUSH_FLAGS;
            end
            OP_ABS_CALL, OP_REL_CALL, OP_IND_CALL, OP_INT_ENTRY: begin
              sp_d       = sp_push;
              wdata_d    = pc_full;
              we_d       = 1'b1;
              req_d      = 1'b1;
              tgt_load_d = 1'b1;
              two_d      = (i_op == OP_INT_ENTRY);
              tgt_d      = (i_op == OP_REL_CALL) ? rel16_pc : i_operand[31:PC_LOW];
              state_d    = ST_PUSH_PC;
              if (i_op == OP_INT_ENTRY) begin
                flags_d[IX_BIT] = i_mid_instr;
              end
            end
            OP_FLAGS_POP, OP_INT_RETURN: begin
              we_d    = 1'b0;
              req_d   = 1'b1;
              two_d   = (i_op == OP_INT_RETURN);
              state_d = ST_POP_FLAGS;
            end
            OP_SUB_RETURN: begin
              we_d    = 1'b0;
              req_d   = 1'b1;
              state_d = ST_POP_PC;
            end
            default: ;
          endcase
        end
      end
      ST_PUSH_PC: begin
        if (i_mem_ack) begin
          if (two_q) begin
            sp_d    = sp_down;
            wdata_d = flags_q;
            state_d = ST_PUSH_FLAGS;
          end else begin
            req_d   = 1'b0;
            we_d    = 1'b0;
            pc_d    = tgt_q;
            state_d = ST_IDLE;
          end
        end
      end
      ST_PUSH_FLAGS: begin
        if (i_mem_ack) begin
          req_d   = 1'b0;
          we_d    = 1'b0;
          state_d = ST_IDLE;
          if (tgt_load_q) begin
            pc_d = tgt_q;
          end
        end
      end
      ST_POP_FLAGS: begin
        if (i_mem_ack) begin
          flags_d = i_mem_rdata & USED_MASK;
          sp_d    = sp_up;
          if (two_q) begin
            state_d = ST_POP_PC;
          end else begin
            req_d   = 1'b0;
            state_d = ST_IDLE;
          end
        end
      end
      ST_POP_PC: begin
        if (i_mem_ack) begin
          pc_d    = i_mem_rdata[31:PC_LOW];
          sp_d    = sp_up;
          req_d   = 1'b0;
          state_d = ST_IDLE;
        end
      end
    endcase
    // A fault in the same cycle as a flags load still leaves its mark.
    if (i_bus_fault) begin
      flags_d[BF_BIT] = 1'b1;
    end
  end

  // ==========================================================
  // Sequential state.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_q    <= FLAGS_RESET;
      pc_q       <= '0;
      sp_q       <= '0;
      tgt_q      <= '0;
      tgt_load_q <= 1'b0;
      two_q      <= 1'b0;
      state_q    <= ST_IDLE;
      req_q      <= 1'b0;
      we_q       <= 1'b0;
      wdata_q    <= '0;
      gwe_q      <= 1'b0;
      gdata_q    <= '0;
    end else begin
      flags_q    <= flags_d;
      pc_q       <= pc_d;
      sp_q       <= sp_d;
      tgt_q      <= tgt_d;
      tgt_load_q <= tgt_load_d;
      two_q      <= two_d;
      state_q    <= state_d;
      req_q      <= req_d;
      we_q       <= we_d;
      wdata_q    <= wdata_d;
      gwe_q      <= gwe_d;
      gdata_q    <= gdata_d;
    end
  end

  // Single-step request and busy flag.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      step_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      step_q <= i_instr_done & flags_q[SS_BIT];
      busy_q <= (state_d != ST_IDLE);
    end
  end

  // Decoded field lengths, one per data field.
  for (genvar g = 0; g < 2; g++) begin : g_field
    wire [4:0] code = flags_d[g*FIELD_SPAN +: 5];
    // Reset width is decoded from the reset flags word, so field 1 starts at 32.
    localparam logic [4:0] RST_CODE = FLAGS_RESET[g*FIELD_SPAN +: 5];
    localparam logic [5:0] RST_LEN  = (RST_CODE == 5'h00) ? FULL_WIDTH : {1'b0, RST_CODE};
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        len_q[g] <= RST_LEN;
      end else begin
        len_q[g] <= (code == 5'h00) ? FULL_WIDTH : {1'b0, code};
      end
    end
  end

  // ==========================================================
  // Outputs, all taken from flip-flops.
  assign o_flags      = flags_q;
  assign o_pc         = pc_full;
  assign o_sp         = sp_q;
  assign o_int_gate   = flags_q[IE_BIT];
  assign o_step_irq   = step_q;
  assign o_field0_len = len_q[0];
  assign o_field1_len = len_q[1];
  assign o_mem_req    = req_q;
  assign o_mem_we     = we_q;
  assign o_mem_addr   = sp_q;
  assign o_mem_wdata  = wdata_q;
  assign o_busy       = busy_q;
  assign o_gpr_we     = gwe_q;
  assign o_gpr_wdata  = gdata_q;
endmodule : cpsrg_regs

// *** cpsrg_pkg.sv ***
// How it works
// - Reset loads the flags word with 0000_0010h.
// - Bits 4:0 give field 0 width, code 0 means 32; bit 5 sign-extends.
// - Bits 10:6 give field 1 width, code 0 means 32; bit 11 sign-extends.
// - Bit 21 gates all maskable interrupts: 0 blocks, 1 allows.
// - Bit 22 set raises an interrupt after every executed instruction.
// - Interrupt entry sets bit 25 if mid-instruction, clears it at a boundary.
// - A local-memory bus fault sets bit 26.
// - Execution updates overflow 28, zero 29, carry 30, negative 31.
// - Bits 12-20, 23-24, 27 clear at reset; software writes zeros there.
// - One op loads the flags word from a register, another copies it out.
// - Carry set/clear and gate on/off ops touch only their own bit.
// - One op writes one field's six bits; another swaps them with a register.
// - Ops push the flags word onto the stack and pop it back.
// - Counter addresses 16-bit words; its low four bits always read zero.
// - Each fetched instruction word advances the counter by one word.
// - Absolute branches load the address with its low four bits cleared.
// - Relative branches add a signed 8/16-bit word displacement shifted by four.
// - Indirect branches load a register value with its low four bits cleared.
// - Ops copy the counter to a register and swap it with a register.
// - One stack pointer, reachable as register 15 from either file.
// - Stack pointer is the bit address of the top value; stack grows down.
// - Calls and interrupts align the stack pointer to 32 bits before pushing.
// - Push lowers the pointer by 32 then stores; pop reads then raises by 32.
// - Interrupt entry pushes the counter first, then the flags word.
// - Interrupt return pops the flags word first, then the counter.
//
// Constants and types of the processor state register block.
// Assumes one processor clock and an instruction decoder issuing one op.
package cpsrg_pkg;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0010;
  localparam logic [31:0] USED_MASK   = 32'hf660_0fff;
  localparam int          FIELD_SPAN  = 6;
  localparam int          FE_OFS      = 5;
  localparam int          IE_BIT      = 21;
  localparam int          SS_BIT      = 22;
  localparam int          IX_BIT      = 25;
  localparam int          BF_BIT      = 26;
  localparam int          C_BIT       = 30;
  localparam int          ARITH_LSB   = 28;
  localparam int          PC_LOW      = 4;
  localparam int          SP_LOW      = 5;
  localparam logic [31:0] STACK_STEP  = 32'h0000_0020;
  localparam logic [5:0]  FULL_WIDTH  = 6'h20;

  typedef enum logic [4:0] {
    OP_NONE, OP_LOAD_FLAGS, OP_COPY_FLAGS, OP_CARRY_SET, OP_CARRY_CLEAR,
    OP_FIELD_WRITE, OP_FIELD_SWAP, OP_INTS_ON, OP_INTS_OFF, OP_FLAGS_PUSH,
    OP_FLAGS_POP, OP_COUNTER_READ, OP_COUNTER_SWAP, OP_ABS_BRANCH,
    OP_REL8_BRANCH, OP_REL16_BRANCH, OP_IND_BRANCH, OP_ABS_CALL,
    OP_REL_CALL, OP_IND_CALL, OP_INT_ENTRY, OP_INT_RETURN, OP_SUB_RETURN,
    OP_SP_WRITE, OP_SP_READ
  } cpsrg_op_type;

  typedef enum {
    ST_IDLE, ST_PUSH_PC, ST_PUSH_FLAGS, ST_POP_FLAGS, ST_POP_PC
  } cpsrg_state_type;
endpackage : cpsrg_pkg

// *** cpsrg_regs_asserts.sv ***
// Assertions on the flags word, counter and stack ports of cpsrg_regs.
// Assumes one clock and an active-low reset; bound onto every cpsrg_regs.
`timescale 1ns/100ps
module cpsrg_regs_asserts (
  // Clock, reset and inputs.
  input wire logic                    i_clk,
  input wire logic                    i_nrst,
  input wire cpsrg_pkg::cpsrg_op_type i_op,
  input wire logic                    i_fetch,
  input wire logic                    i_instr_done,
  input wire logic                    i_alu_we,
  input wire logic                    i_bus_fault,
  input wire logic                    i_mem_ack,
  // Outputs watched.
  input wire logic                    o_mem_req,
  input wire logic                    o_mem_we,
  input wire logic [31:0]             o_mem_addr,
  input wire logic                    o_busy,
  input wire logic [31:0]             o_flags,
  input wire logic [31:0]             o_pc,
  input wire logic [31:0]             o_sp,
  input wire logic                    o_int_gate,
  input wire logic                    o_step_irq,
  input wire logic [5:0]              o_field0_len
);
  import cpsrg_pkg::*;
  // ==========================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Stack sequences taken while idle.
  sequence s_push_take;
    !o_busy && i_op == OP_FLAGS_PUSH;
  endsequence
  sequence s_int_take;
    !o_busy && i_op == OP_INT_ENTRY;
  endsequence
  a_pc_aligned: assert property (o_pc[3:0] == 4'h0)
    else $error("counter low bits not zero");
  a_reserved_zero: assert property ((o_flags & ~USED_MASK) == 32'h0)
    else $error("reserved flag bits set");
  a_gate_mirror: assert property (o_int_gate == o_flags[IE_BIT])
    else $error("interrupt gate differs from flag");
  a_field0_len: assert property (o_field0_len ==
      ((o_flags[4:0] == 5'h0) ? FULL_WIDTH : {1'b0, o_flags[4:0]}))
    else $error("field 0 width decode wrong");
  a_fetch_advance: assert property (i_fetch && !o_busy && i_op == OP_NONE
      |=> o_pc == $past(o_pc) + 32'h10)
    else $error("fetch did not advance counter");
  a_carry_only: assert property (!o_busy && i_op == OP_CARRY_SET
      && !i_alu_we && !i_bus_fault |=> o_flags == ($past(o_flags) | 32'h4000_0000))
    else $error("carry set touched other bits");
  a_step_pulse: assert property (i_instr_done && o_flags[SS_BIT] |=> o_step_irq)
    else $error("single step pulse missing");
  a_fault_sets: assert property (i_bus_fault |=> o_flags[BF_BIT])
    else $error("bus fault flag not set");
  a_push_start: assert property (s_push_take |=> o_mem_req && o_mem_we &&
      o_mem_addr == $past(o_sp) - STACK_STEP)
    else $error("push did not lower pointer first");
  a_entry_align: assert property (s_int_take |=> o_mem_req && o_mem_we &&
      o_mem_addr == (($past(o_sp) & ~32'h1f) - STACK_STEP))
    else $error("entry push not aligned");
  a_req_stands: assert property (o_mem_req && !i_mem_ack |=> o_mem_req &&
      $stable(o_mem_addr) && $stable(o_mem_we))
    else $error("stack request changed before ack");
endmodule : cpsrg_regs_asserts

bind cpsrg_regs cpsrg_regs_asserts cpsrg_regs_asserts_inst (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_op(i_op), .i_fetch(i_fetch),
  .i_instr_done(i_instr_done), .i_alu_we(i_alu_we), .i_bus_fault(i_bus_fault),
  .i_mem_ack(i_mem_ack), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
  .o_mem_addr(o_mem_addr), .o_busy(o_busy), .o_flags(o_flags), .o_pc(o_pc),
  .o_sp(o_sp), .o_int_gate(o_int_gate), .o_step_irq(o_step_irq),
  .o_field0_len(o_field0_len));

// *** cpsrg_stack_mem.sv ***
// Local memory model that holds the system stack, one 32-bit word a request.
// Assumes requests held until ack; i_delay sets the wait before each ack.
`timescale 1ns/100ps
module cpsrg_stack_mem (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Stack request side.
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_delay,
  output logic             o_ack,
  output logic [31:0]      o_rdata
);
  logic [31:0] mem [64];
  logic [3:0]  wait_q;
  // Word slot taken from the bit address: 64 words of 32 bits each.
  wire  [5:0]  slot = i_addr[10:5];
  // Read data is valid only in the ack cycle; otherwise a changing pattern.
  assign o_rdata = o_ack ? mem[slot] : ~i_addr;
  // Count the wait, then acknowledge once and store a push.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack  <= 1'b0;
      wait_q <= 4'h0;
    end else if (o_ack || !i_req) begin
      o_ack  <= 1'b0;
      wait_q <= 4'h0;
    end else if (wait_q == i_delay) begin
      o_ack <= 1'b1;
      if (i_we) mem[slot] <= i_wdata;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : cpsrg_stack_mem

// *** cpsrg_regs_tb_top.sv ***
// Testbench for cpsrg_regs with the stack memory model on its far side.
// Assumes inputs change at the falling edge and ops wait out o_busy.
`timescale 1ns/100ps
module cpsrg_regs_tb_top;
  import cpsrg_pkg::*;
  logic i_clk, i_nrst, i_field_sel, i_mid_instr, i_fetch, i_instr_done;
  logic i_alu_we, i_bus_fault, i_mem_ack, o_mem_req, o_mem_we, o_busy;
  logic o_int_gate, o_step_irq, o_gpr_we;
  logic [3:0] i_alu_flags, delay;
  logic [5:0] o_field0_len, o_field1_len;
  logic [31:0] i_operand, i_mem_rdata, o_mem_addr, o_mem_wdata, o_flags;
  logic [31:0] o_pc, o_sp, o_gpr_wdata, f;
  cpsrg_op_type i_op;
  int failures, check_count, cyc;
  // ==========================================
  // Design and stack memory
  cpsrg_regs cpsrg_regs_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_op(i_op),
    .i_operand(i_operand), .i_field_sel(i_field_sel), .i_mid_instr(i_mid_instr),
    .i_fetch(i_fetch), .i_instr_done(i_instr_done), .i_alu_we(i_alu_we),
    .i_alu_flags(i_alu_flags), .i_bus_fault(i_bus_fault), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_busy(o_busy),
    .o_flags(o_flags), .o_pc(o_pc), .o_sp(o_sp), .o_int_gate(o_int_gate),
    .o_step_irq(o_step_irq), .o_field0_len(o_field0_len),
    .o_field1_len(o_field1_len), .o_gpr_we(o_gpr_we), .o_gpr_wdata(o_gpr_wdata));
  cpsrg_stack_mem cpsrg_stack_mem_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
    .i_delay(delay), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  // ==========================================
  // Tasks
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Present one op for one edge, then wait out any stack sequence.
  task automatic op(input cpsrg_op_type o, input logic [31:0] v);
    int n;
    n = 0;
    @(negedge i_clk);
    i_op = o;
    i_operand = v;
    @(negedge i_clk);
    i_op = OP_NONE;
    while (o_busy !== 1'b0 && n < 60) begin
      @(negedge i_clk);
      n++;
    end
    // A stack sequence that never ends counts as a mismatch.
    if (n == 60) begin
      failures++;
      $display("mismatch at %0t: stack op never finished", $time);
    end
  endtask : op
  // One-cycle pulse on {alu write, bus fault, instr done, fetch}.
  task automatic pulse(input logic [3:0] w);
    @(negedge i_clk);
    {i_alu_we, i_bus_fault, i_instr_done, i_fetch} = w;
    @(negedge i_clk);
    {i_alu_we, i_bus_fault, i_instr_done, i_fetch} = 4'h0;
  endtask : pulse
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // ==========================================
  // Clock and timeout
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end
  // ==========================================
  // Tests
  initial begin
    {i_nrst, i_field_sel, i_mid_instr, i_fetch, i_instr_done} = 5'h0;
    {i_alu_we, i_bus_fault, i_alu_flags, delay, i_operand} = 42'h0;
    i_op = OP_NONE;
    repeat (8) @(negedge i_clk);
    i_nrst = 1'b1;
    chk(o_flags, FLAGS_RESET);
    chk({o_field0_len, o_field1_len}, {6'h10, FULL_WIDTH});
    $display("reset test done");
    op(OP_LOAD_FLAGS, 32'hffff_ffff);
    f = USED_MASK;
    chk(o_flags, f);
    pulse(4'h2);
    chk(o_step_irq, 1'b1);
    op(OP_CARRY_CLEAR, 32'h0);
    f[C_BIT] = 1'b0;
    chk(o_flags, f);
    op(OP_INTS_OFF, 32'h0);
    f[IE_BIT] = 1'b0;
    chk({o_int_gate, o_flags}, {1'b0, f});
    op(OP_FIELD_WRITE, 32'h20);
    f[5:0] = 6'h20;
    chk({o_field0_len, o_flags}, {FULL_WIDTH, f});
    i_field_sel = 1'b1;
    op(OP_FIELD_SWAP, 32'habcd_ef05);
    f[11:6] = 6'h05;
    chk({o_field1_len, o_flags}, {6'h05, f});
    chk(o_gpr_wdata, 32'habcd_ef3f);
    op(OP_COPY_FLAGS, 32'h0);
    chk({o_gpr_we, o_gpr_wdata}, {1'b1, f});
    op(OP_INTS_ON, 32'h0);
    op(OP_CARRY_SET, 32'h0);
    f[IE_BIT] = 1'b1;
    f[C_BIT] = 1'b1;
    chk({o_int_gate, o_flags}, {1'b1, f});
    op(OP_LOAD_FLAGS, 32'h0020_0010);
    f = 32'h0020_0010;
    i_alu_flags = 4'ha;
    pulse(4'h8);
    pulse(4'h4);
    pulse(4'h2);
    f[31:28] = 4'ha;
    f[BF_BIT] = 1'b1;
    chk({o_step_irq, o_flags}, {1'b0, f});
    $display("flags test done");
    op(OP_ABS_BRANCH, 32'h1235);
    chk(o_pc, 32'h1230);
    pulse(4'h1);
    chk(o_pc, 32'h1240);
    op(OP_REL8_BRANCH, 32'h0000_00fe);
    chk(o_pc, 32'h1220);
    op(OP_REL16_BRANCH, 32'h0000_0010);
    chk(o_pc, 32'h1320);
    op(OP_IND_BRANCH, 32'h8000_000f);
    chk(o_pc, 32'h8000_0000);
    op(OP_COUNTER_SWAP, 32'h5557);
    chk({o_gpr_wdata, o_pc}, {32'h8000_0000, 32'h5550});
    op(OP_COUNTER_READ, 32'h0);
    chk(o_gpr_wdata, 32'h5550);
    $display("counter test done");
    op(OP_SP_WRITE, 32'h105);
    op(OP_SP_READ, 32'h0);
    chk(o_gpr_wdata, 32'h105);
    i_mid_instr = 1'b1;
    op(OP_INT_ENTRY, 32'h4008);
    f[IX_BIT] = 1'b1;
    chk(cpsrg_stack_mem_inst.mem[7], 32'h5550);
    chk(cpsrg_stack_mem_inst.mem[6], f);
    chk({o_sp, o_pc}, {32'hc0, 32'h4000});
    delay = 4'h3;
    op(OP_CARRY_SET, 32'h0);
    op(OP_INT_RETURN, 32'h0);
    chk({o_flags, o_pc, o_sp}, {f, 32'h5550, 32'h100});
    op(OP_FLAGS_PUSH, 32'h0);
    chk({cpsrg_stack_mem_inst.mem[7], o_sp}, {f, 32'he0});
    op(OP_CARRY_SET, 32'h0);
    op(OP_FLAGS_POP, 32'h0);
    chk({o_flags, o_sp}, {f, 32'h100});
    op(OP_REL_CALL, 32'h0000_fffe);
    chk({cpsrg_stack_mem_inst.mem[7], o_pc}, {32'h5550, 32'h5530});
    op(OP_SUB_RETURN, 32'h0);
    chk({o_pc, o_sp}, {32'h5550, 32'h100});
    $display("stack test done");
    end_sim();
  end
endmodule : cpsrg_regs_tb_top
